//--- rtl/irq_timer_sleep_unit.sv
// Overview of operation
// - Three port-three lines pick digital or analog mode; lines 0 and 1 then take comparator input; feed interrupts and timer.
// - Two 8-bit timers, each with a 6-bit prescaler; only timer one external.
// - Prescalers divide by 1 to 64; counters count down from 1 to 256.
// - Counter and prescaler both ending raise request four or five.
// - Software can start, stop, resume, or restart each counter from its load.
// - Each counter runs single-pass to zero or reloads continuously.
// - Counter reads never disturb counting; prescalers cannot be read.
// - Timer one clocks from processor clock over four or an external line.
// - External timer line acts as clock, retrigger, one-shot trigger, or gate.
// - Requests come from fixed pin edges and the two timer end events.
// - Request n vectors through program bytes 2n and 2n+1.
// - Mask register enables requests globally and each one alone.
// - Programmable priority picks one among several pending requests.
// - A grant disables interrupts; core saves state and branches to vector.
// - Request register stays readable while masked, for polling.
// - Halt stops core clock only; timers and pin edges keep working.
// - Halt ends only on a taken interrupt; core resumes after halt.
// - Stop kills clocks and oscillator; low recovery pin restarts at 000C.
// - Stop recovery leaves the port two mode register untouched.
// - Recovery pin low ends stop even when the pin is an output.
`timescale 1ns/1ps

module irq_timer_sleep_unit
(
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    input  wire logic                        timer_in_analog1_pin,
    input  wire logic                        analog2_pin,
    input  wire logic                        reference_pin,
    input  wire logic                        comparator_input_one,
    input  wire logic                        comparator_input_two,
    input  wire logic                        stop_recovery_pin,
    input  wire logic                        int_ack,
    output irq_timer_pkg::core_out_s         core_out,
    output logic      [7:0]                  port_two_mode_reg
);

    irq_timer_pkg::unit_state_s r;
    irq_timer_pkg::unit_state_s n;

    // Rotating priority: the programmed index is served first, then upward.
    function automatic logic [3:0] pick
    (
        input logic [5:0] cand,
        input logic [2:0] start
    );
        logic [3:0] res;
        int         k;
        res = 4'h0;
        for (int i = irq_timer_pkg::NUM_IRQ - 1; i >= 0; i--)
        begin
            k = (int'(start) + i) % irq_timer_pkg::NUM_IRQ;
            if (cand[k])
            begin
                res = {1'b1, 3'(k)};
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] reg_read
    (
        input irq_timer_pkg::unit_state_s s,
        input logic [7:0]                 addr
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        case (addr)
            irq_timer_pkg::OFF_TMR_CTRL:
            begin
                d[irq_timer_pkg::TC_T0_RUN]  = s.tmr[0].run;
                d[irq_timer_pkg::TC_T0_CONT] = s.tmr[0].cont;
                d[irq_timer_pkg::TC_T1_RUN]  = s.tmr[1].run;
                d[irq_timer_pkg::TC_T1_CONT] = s.tmr[1].cont;
                d[irq_timer_pkg::TC_T1_MODE_LO +: 3] = s.t1_mode;
            end
            irq_timer_pkg::OFF_T0_DATA:  d[7:0] = s.tmr[0].cnt;
            irq_timer_pkg::OFF_T1_DATA:  d[7:0] = s.tmr[1].cnt;
            irq_timer_pkg::OFF_IRQ_REQ:  d[5:0] = s.pend;
            irq_timer_pkg::OFF_IRQ_MASK:
            begin
                d[5:0] = s.mask;
                d[irq_timer_pkg::MASK_GLOBAL] = s.gen;
            end
            irq_timer_pkg::OFF_IRQ_PRIO: d[2:0] = s.prio;
            irq_timer_pkg::OFF_P3_MODE:  d[2:0] = s.p3_analog;
            irq_timer_pkg::OFF_P2_MODE:  d[7:0] = s.p2m;
            irq_timer_pkg::OFF_POWER:    d[1:0] = s.pwr;
            default:                     d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    logic [2:0] raw_lines;
    logic [2:0] fall;
    logic [2:0] rise;
    logic       clocks_on;
    logic       tick4;
    logic [1:0] tick;
    logic [1:0] trig;
    logic [1:0] tend;
    logic [5:0] set_irq;
    logic [5:0] clr_irq;
    logic [3:0] winner;
    logic       wr;
    logic       take_ack;

    always_comb
    begin
        n        = r;
        n.restart = 1'b0;
        clr_irq  = 6'h00;
        trig     = 2'b00;
        tick     = 2'b00;
        tend     = 2'b00;

        // Line 0 is the timer input and first analog line. The reference
        // line in analog mode feeds the comparator, so its edge path idles.
        raw_lines[0] = r.p3_analog[0] ? comparator_input_one
                                      : timer_in_analog1_pin;
        raw_lines[1] = r.p3_analog[1] ? comparator_input_two
                                      : analog2_pin;
        raw_lines[2] = r.p3_analog[2] ? 1'b1 : reference_pin;

        n.sync1 = raw_lines;
        n.sync2 = r.sync1;
        n.sync3 = r.sync2;
        n.stop1 = stop_recovery_pin;
        n.stop2 = r.stop1;

        clocks_on = (r.pwr != irq_timer_pkg::PWR_STOP);
        fall = (r.sync3 & ~r.sync2) & {3{clocks_on}};
        rise = (~r.sync3 & r.sync2) & {3{clocks_on}};

        if (clocks_on)
        begin
            n.div = r.div + 2'd1;
        end
        tick4 = clocks_on && (r.div == 2'(irq_timer_pkg::INT_CLK_DIV - 1));

        tick[0] = tick4;
        case (r.t1_mode)
            irq_timer_pkg::T1_INTERNAL:  tick[1] = tick4;
            irq_timer_pkg::T1_EXT_CLOCK: tick[1] = fall[0];
            irq_timer_pkg::T1_RETRIG:
            begin
                tick[1] = tick4;
                trig[1] = fall[0];
            end
            irq_timer_pkg::T1_NONRETRIG:
            begin
                tick[1] = tick4;
                trig[1] = fall[0] & ~r.tmr[1].run;
            end
            irq_timer_pkg::T1_GATE:      tick[1] = tick4 & r.sync2[0];
            default:                     tick[1] = tick4;
        endcase

        // A load value of zero means 256 counts and a prescale of zero
        // means divide by 64, since both wrap through zero on the way down.
        for (int i = 0; i < 2; i++)
        begin
            if (trig[i])
            begin
                n.tmr[i].cnt = r.tmr[i].reload;
                n.tmr[i].pre = r.tmr[i].pscale;
                n.tmr[i].run = 1'b1;
            end
            else if (r.tmr[i].run && tick[i])
            begin
                if (r.tmr[i].pre == 6'd1)
                begin
                    n.tmr[i].pre = r.tmr[i].pscale;
                    if (r.tmr[i].cnt == 8'd1)
                    begin
                        tend[i] = 1'b1;
                        if (r.tmr[i].cont)
                        begin
                            n.tmr[i].cnt = r.tmr[i].reload;
                        end
                        else
                        begin
                            n.tmr[i].cnt = 8'h00;
                            n.tmr[i].run = 1'b0;
                        end
                    end
                    else
                    begin
                        n.tmr[i].cnt = r.tmr[i].cnt - 8'd1;
                    end
                end
                else
                begin
                    n.tmr[i].pre = r.tmr[i].pre - 6'd1;
                end
            end
        end

        set_irq = {tend[1], tend[0], rise[1], fall[0], fall[2], fall[1]};

        // Register writes land in the data phase.
        wr = r.dp_act && r.dp_wr;
        if (wr)
        begin
            case (r.dp_addr)
                irq_timer_pkg::OFF_TMR_CTRL:
                begin
                    n.tmr[0].run  = hwdata[irq_timer_pkg::TC_T0_RUN];
                    n.tmr[0].cont = hwdata[irq_timer_pkg::TC_T0_CONT];
                    n.tmr[1].run  = hwdata[irq_timer_pkg::TC_T1_RUN];
                    n.tmr[1].cont = hwdata[irq_timer_pkg::TC_T1_CONT];
                    n.t1_mode = irq_timer_pkg::t1_mode_e'(
                        hwdata[irq_timer_pkg::TC_T1_MODE_LO +: 3]);
                    if (hwdata[irq_timer_pkg::TC_T0_LOAD])
                    begin
                        n.tmr[0].cnt = r.tmr[0].reload;
                        n.tmr[0].pre = r.tmr[0].pscale;
                    end
                    if (hwdata[irq_timer_pkg::TC_T1_LOAD])
                    begin
                        n.tmr[1].cnt = r.tmr[1].reload;
                        n.tmr[1].pre = r.tmr[1].pscale;
                    end
                end
                irq_timer_pkg::OFF_T0_DATA:  n.tmr[0].reload = hwdata[7:0];
                irq_timer_pkg::OFF_T1_DATA:  n.tmr[1].reload = hwdata[7:0];
                irq_timer_pkg::OFF_PRESCALE:
                begin
                    n.tmr[0].pscale = hwdata[5:0];
                    n.tmr[1].pscale = hwdata[irq_timer_pkg::PS_T1_LO +: 6];
                end
                irq_timer_pkg::OFF_IRQ_REQ:  clr_irq = hwdata[5:0];
                irq_timer_pkg::OFF_IRQ_MASK:
                begin
                    n.mask = hwdata[5:0];
                    n.gen  = hwdata[irq_timer_pkg::MASK_GLOBAL];
                end
                irq_timer_pkg::OFF_IRQ_PRIO: n.prio = hwdata[2:0];
                irq_timer_pkg::OFF_P3_MODE:  n.p3_analog = hwdata[2:0];
                irq_timer_pkg::OFF_P2_MODE:  n.p2m = hwdata[7:0];
                irq_timer_pkg::OFF_POWER:
                begin
                    // The preceding no-op is the program's duty; a sleep
                    // request is honoured only from the running state.
                    if (r.pwr == irq_timer_pkg::PWR_RUN)
                    begin
                        if (hwdata[irq_timer_pkg::PWR_STOP_BIT])
                        begin
                            n.pwr = irq_timer_pkg::PWR_STOP;
                        end
                        else if (hwdata[irq_timer_pkg::PWR_HALT_BIT])
                        begin
                            n.pwr = irq_timer_pkg::PWR_HALT;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Grant: the core has taken the vector and saves its own state.
        take_ack = int_ack && r.req;
        if (take_ack)
        begin
            clr_irq[r.sel] = 1'b1;
            n.gen = 1'b0;
            if (r.pwr == irq_timer_pkg::PWR_HALT)
            begin
                n.pwr = irq_timer_pkg::PWR_RUN;
            end
        end

        // A new event in the clearing cycle survives the clear.
        n.pend = (r.pend & ~clr_irq) | set_irq;

        // The recovery pin is sampled whatever its port direction.
        if ((r.pwr == irq_timer_pkg::PWR_STOP) && !r.stop2)
        begin
            n.pwr     = irq_timer_pkg::PWR_RUN;
            n.restart = 1'b1;
            n.gen     = 1'b0;
            n.p2m     = r.p2m;
        end

        winner = pick(n.pend & n.mask & {6{n.gen}}, n.prio);
        n.req  = winner[3];
        n.sel  = winner[2:0];

        // AHB-Lite: reads take one wait state so that a read straight
        // after a write returns the freshly written value.
        if (hreadyout)
        begin
            n.dp_act  = hsel && hready && htrans[1];
            n.dp_wr   = hwrite;
            n.dp_addr = {haddr[7:2], 2'b00};
            n.rd_ok   = 1'b0;
        end
        else
        begin
            n.rd_ok = 1'b1;
            n.rdata = reg_read(r, r.dp_addr);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r           <= '0;
            r.t1_mode   <= irq_timer_pkg::T1_INTERNAL;
            r.pwr       <= irq_timer_pkg::PWR_RUN;
            r.p2m       <= irq_timer_pkg::P2_MODE_RST;
            r.sync1     <= 3'h7;
            r.sync2     <= 3'h7;
            r.sync3     <= 3'h7;
            r.stop1     <= 1'b1;
            r.stop2     <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    assign hreadyout = !(r.dp_act && !r.dp_wr && !r.rd_ok);
    assign hresp     = 1'b0;
    assign hrdata    = r.rdata;

    assign core_out.int_req      = r.req;
    assign core_out.int_vector   = {12'h000, r.sel, 1'b0};
    assign core_out.cpu_clk_en   = (r.pwr == irq_timer_pkg::PWR_RUN);
    assign core_out.osc_en       = (r.pwr != irq_timer_pkg::PWR_STOP);
    assign core_out.restart      = r.restart;
    assign core_out.restart_addr = irq_timer_pkg::STOP_RESTART;
    assign port_two_mode_reg     = r.p2m;

endmodule

//--- rtl/irq_timer_pkg.sv
package irq_timer_pkg;

    // Internal processor clock divided by four drives timer zero, and timer one except in external clock mode.
    localparam int         INT_CLK_DIV   = 4;
    localparam int         NUM_IRQ       = 6;

    // Register byte offsets (low eight address bits).
    localparam logic [7:0] OFF_TMR_CTRL  = 8'h00;
    localparam logic [7:0] OFF_T0_DATA   = 8'h04;
    localparam logic [7:0] OFF_T1_DATA   = 8'h08;
    localparam logic [7:0] OFF_PRESCALE  = 8'h0c;
    localparam logic [7:0] OFF_IRQ_REQ   = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;
    localparam logic [7:0] OFF_IRQ_PRIO  = 8'h18;
    localparam logic [7:0] OFF_P3_MODE   = 8'h1c;
    localparam logic [7:0] OFF_P2_MODE   = 8'h20;
    localparam logic [7:0] OFF_POWER     = 8'h24;

    // Timer control, prescale, mask and power register fields.
    localparam int         TC_T0_LOAD    = 0;
    localparam int         TC_T0_RUN     = 1;
    localparam int         TC_T0_CONT    = 2;
    localparam int         TC_T1_LOAD    = 3;
    localparam int         TC_T1_RUN     = 4;
    localparam int         TC_T1_CONT    = 5;
    localparam int         TC_T1_MODE_LO = 6;
    localparam int         PS_T1_LO      = 8;
    localparam int         MASK_GLOBAL   = 7;
    localparam int         PWR_HALT_BIT  = 0;
    localparam int         PWR_STOP_BIT  = 1;

    localparam logic [7:0]  P2_MODE_RST  = 8'hff;
    localparam logic [15:0] STOP_RESTART = 16'h000c;

    typedef enum logic [1:0] {
        PWR_RUN  = 2'b00,
        PWR_HALT = 2'b01,
        PWR_STOP = 2'b11
    } pwr_e;

    typedef enum logic [2:0] {
        T1_INTERNAL  = 3'b000,
        T1_EXT_CLOCK = 3'b001,
        T1_RETRIG    = 3'b011,
        T1_NONRETRIG = 3'b010,
        T1_GATE      = 3'b110
    } t1_mode_e;

    typedef struct packed {
        logic [7:0] reload;
        logic [5:0] pscale;
        logic [7:0] cnt;
        logic [5:0] pre;
        logic       run;
        logic       cont;
    } tmr_s;

    typedef struct packed {
        logic        int_req;
        logic [15:0] int_vector;
        logic        cpu_clk_en;
        logic        osc_en;
        logic        restart;
        logic [15:0] restart_addr;
    } core_out_s;

    typedef struct packed {
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic [2:0]  sync3;
        logic        stop1;
        logic        stop2;
        logic [1:0]  div;
        tmr_s [1:0]  tmr;
        t1_mode_e    t1_mode;
        logic [5:0]  pend;
        logic [5:0]  mask;
        logic        gen;
        logic [2:0]  prio;
        logic        req;
        logic [2:0]  sel;
        logic [2:0]  p3_analog;
        logic [7:0]  p2m;
        pwr_e        pwr;
        logic        restart;
        logic        dp_act;
        logic        dp_wr;
        logic [7:0]  dp_addr;
        logic        rd_ok;
        logic [31:0] rdata;
    } unit_state_s;

endpackage

//--- sim/irq_timer_sleep_unit_chk.sv
`timescale 1ns/1ps

module irq_timer_sleep_unit_chk
(
    input wire logic                     hclk,
    input wire logic                     hresetn,
    input wire logic                     hsel,
    input wire logic [1:0]               htrans,
    input wire logic                     hwrite,
    input wire logic                     hready,
    input wire logic                     hreadyout,
    input wire logic                     int_ack,
    input wire irq_timer_pkg::core_out_s core_out,
    input wire logic [7:0]               port_two_mode_reg
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // A read is answered after exactly one wait state.
    property p_rd_wait;
        hsel && hready && htrans[1] && !hwrite && hreadyout
            |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read data phase length wrong");

    property p_stop_clk;
        !core_out.osc_en |-> !core_out.cpu_clk_en;
    endproperty
    a_stop_clk: assert property (p_stop_clk)
        else $error("core clock runs without oscillator");

    property p_restart_addr;
        core_out.restart_addr == 16'h000c;
    endproperty
    a_restart_addr: assert property (p_restart_addr)
        else $error("restart address wrong");

    property p_restart_pulse;
        core_out.restart |-> core_out.osc_en && core_out.cpu_clk_en
            ##1 !core_out.restart;
    endproperty
    a_restart_pulse: assert property (p_restart_pulse)
        else $error("restart pulse wrong");

    property p_vec;
        core_out.int_req |-> !core_out.int_vector[0]
            && core_out.int_vector <= 16'h000a;
    endproperty
    a_vec: assert property (p_vec)
        else $error("vector out of range");

    property p_ack_drop;
        int_ack && core_out.int_req |-> ##2 !core_out.int_req;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("request stays after grant");

    property p_halt_wake;
        !core_out.cpu_clk_en && core_out.osc_en && int_ack
            && core_out.int_req |=> core_out.cpu_clk_en;
    endproperty
    a_halt_wake: assert property (p_halt_wake)
        else $error("grant does not end halt");

    property p_halt_hold;
        !core_out.cpu_clk_en && core_out.osc_en
            && !(int_ack && core_out.int_req) |=> !core_out.cpu_clk_en;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("halt ended without grant");

    property p_p2m;
        $rose(core_out.osc_en) |-> $stable(port_two_mode_reg);
    endproperty
    a_p2m: assert property (p_p2m)
        else $error("port mode changed by stop recovery");
endmodule

bind irq_timer_sleep_unit irq_timer_sleep_unit_chk u_chk
(
    .hclk              (hclk),
    .hresetn           (hresetn),
    .hsel              (hsel),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hready            (hready),
    .hreadyout         (hreadyout),
    .int_ack           (int_ack),
    .core_out          (core_out),
    .port_two_mode_reg (port_two_mode_reg)
);

//--- sim/core_model.sv
`timescale 1ns/1ps

module core_model
(
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     slow,
    input  wire irq_timer_pkg::core_out_s core_out,
    output logic                          int_ack
);
    logic [2:0] wait_c;
    logic       busy;
    logic       acked;

    // One grant per request; the request must fall before the next.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            busy    <= 1'b0;
            acked   <= 1'b0;
            wait_c  <= 3'h0;
            int_ack <= 1'b0;
        end
        else
        begin
            int_ack <= 1'b0;
            if (!busy && core_out.int_req)
            begin
                busy   <= 1'b1;
                wait_c <= slow ? 3'h5 : 3'h0;
            end
            else if (busy && wait_c != 3'h0)
                wait_c <= wait_c - 3'h1;
            else if (busy && !acked)
            begin
                int_ack <= 1'b1;
                acked   <= 1'b1;
            end
            else if (acked && !core_out.int_req)
            begin
                busy  <= 1'b0;
                acked <= 1'b0;
            end
        end
    end
endmodule

//--- sim/irq_timer_sleep_unit_tb.sv
`timescale 1ns/1ps

module irq_timer_sleep_unit_tb;
    logic                     hclk = 1'b0;
    logic                     hresetn = 1'b0;
    logic [31:0]              haddr = 32'h0;
    logic [1:0]               htrans = 2'h0;
    logic                     hwrite = 1'b0;
    logic [31:0]              hwdata = 32'h0;
    logic [31:0]              hrdata;
    logic                     hreadyout;
    logic                     hresp;
    logic [4:0]               lines = 5'h1f;
    logic                     srp = 1'b1;
    logic                     slow = 1'b0;
    logic                     int_ack;
    irq_timer_pkg::core_out_s core_out;
    logic [7:0]               p2m;
    logic [7:0]               p2m_v;
    logic                     rd_ph = 1'b0;
    logic [31:0]              rq[$];
    logic [15:0]              vq[$];
    int                       order[4] = '{3, 1, 2, 0};
    int                       n_errors = 0;
    int                       comparisons = 0;
    integer                   seed = 32'hcbda;
    logic [31:0]              rnd;

    always #5 hclk = ~hclk;

    irq_timer_sleep_unit dut
    (
        .hclk                 (hclk),
        .hresetn              (hresetn),
        .hsel                 (1'b1),
        .haddr                (haddr),
        .htrans               (htrans),
        .hwrite               (hwrite),
        .hsize                (3'h2),
        .hwdata               (hwdata),
        .hready               (hreadyout),
        .hrdata               (hrdata),
        .hreadyout            (hreadyout),
        .hresp                (hresp),
        .timer_in_analog1_pin (lines[0]),
        .analog2_pin          (lines[1]),
        .reference_pin        (lines[2]),
        .comparator_input_one (lines[3]),
        .comparator_input_two (lines[4]),
        .stop_recovery_pin    (srp),
        .int_ack              (int_ack),
        .core_out             (core_out),
        .port_two_mode_reg    (p2m)
    );

    core_model u_core
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .slow     (slow),
        .core_out (core_out),
        .int_ack  (int_ack)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic pulse(input int i);
        lines[i] <= 1'b0;
        cyc(5);
        lines[i] <= 1'b1;
        cyc(5);
    endtask

    task automatic wait_ack();
        int k;
        for (k = 0; k < 50 && int_ack !== 1'b1; k++)
            @(posedge hclk);
        chk({31'h0, int_ack}, 32'h1);
        cyc(3);
    endtask

    task automatic conclude();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Results are matched against the oldest note as they appear.
    always @(posedge hclk)
    begin
        if (rd_ph && hreadyout === 1'b1)
            chk(hrdata, rq.pop_front());
        if (hreadyout === 1'b1)
            rd_ph <= htrans[1] && !hwrite;
        if (int_ack === 1'b1 && core_out.int_req === 1'b1)
            chk({16'h0, core_out.int_vector}, {16'h0, vq.pop_front()});
    end

    initial
    begin
        #100000;
        n_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        conclude();
    end

    initial
    begin
        int k;
        cyc(3);
        hresetn <= 1'b1;
        cyc(1);
        chk({30'h0, core_out.cpu_clk_en, core_out.osc_en}, 32'h3);
        chk({31'h0, hresp}, 32'h0);
        chk({24'h0, p2m}, 32'hff);
        rd(8'h20, 32'hff);
        rd(8'h24, 32'h0);
        rd(8'h28, 32'h0);
        rd(8'h0c, 32'h0);
        $display("test reset done");
        rnd = $random(seed);
        p2m_v = rnd[15:8];
        wr(8'h08, {24'h0, rnd[7:0]});
        wr(8'h00, 32'h8);
        rd(8'h08, {24'h0, rnd[7:0]});
        rd(8'h08, {24'h0, rnd[7:0]});
        wr(8'h20, {24'h0, p2m_v});
        $display("test readback done");
        wr(8'h0c, 32'h0102);
        wr(8'h04, 32'h3);
        wr(8'h00, 32'h3);
        rd(8'h10, 32'h0);
        cyc(30);
        rd(8'h10, 32'h10);
        rd(8'h04, 32'h0);
        wr(8'h10, 32'h10);
        cyc(40);
        rd(8'h10, 32'h0);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h7);
        cyc(20);
        wr(8'h10, 32'h10);
        cyc(20);
        rd(8'h10, 32'h10);
        wr(8'h00, 32'h4);
        wr(8'h10, 32'h10);
        cyc(40);
        rd(8'h10, 32'h0);
        wr(8'h00, 32'h6);
        cyc(40);
        rd(8'h10, 32'h10);
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h3f);
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h58);
        pulse(0);
        pulse(0);
        rd(8'h10, 32'h24);
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h3f);
        // Gate mode: a low timer line must hold the count still.
        wr(8'h00, 32'h198);
        lines[0] <= 1'b0;
        cyc(40);
        rd(8'h10, 32'h04);
        lines[0] <= 1'b1;
        cyc(20);
        rd(8'h10, 32'h24);
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h3f);
        $display("test timers done");
        pulse(1);
        pulse(2);
        wr(8'h1c, 32'h1);
        pulse(3);
        rd(8'h10, 32'h0f);
        wr(8'h1c, 32'h0);
        foreach (order[i])
        begin
            slow <= order[i][0];
            vq.push_back(16'(2 * order[i]));
            wr(8'h18, 32'(order[i]));
            wr(8'h14, 32'h8f);
            wait_ack();
        end
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0f);
        $display("test interrupts done");
        wr(8'h24, 32'h1);
        rd(8'h24, 32'h1);
        chk({31'h0, core_out.cpu_clk_en}, 32'h0);
        vq.push_back(16'h2);
        wr(8'h14, 32'h82);
        lines[2] <= 1'b0;
        wait_ack();
        lines[2] <= 1'b1;
        chk({31'h0, core_out.cpu_clk_en}, 32'h1);
        $display("test halt done");
        wr(8'h24, 32'h2);
        cyc(2);
        chk({30'h0, core_out.cpu_clk_en, core_out.osc_en}, 32'h0);
        pulse(2);
        srp <= 1'b0;
        for (k = 0; k < 20 && core_out.restart !== 1'b1; k++)
            @(posedge hclk);
        chk({15'h0, core_out.restart, core_out.restart_addr}, 32'h1000c);
        srp <= 1'b1;
        cyc(2);
        rd(8'h20, {24'h0, p2m_v});
        chk({24'h0, p2m}, {24'h0, p2m_v});
        rd(8'h24, 32'h0);
        rd(8'h10, 32'h0);
        $display("test stop done");
        conclude();
    end
endmodule
